// File: rtl/rtcct_device.sv
// Purpose: countdown timer, external timebase test mode, reset override and serial slave port
// Assumes: scl and sda synchronous to hclk; timebase ticks derived from hclk
// Notes: registers reached through the serial link, seconds also driven out on seconds_o
// Notes on behaviour
// - eight-bit down-counter runs while run bit set
// - source select picks 4096, 64, 1, 1/60 Hz
// - load value n of 1 to 255 gives n over frequency; zero never counts
// - interrupt enable and flag live in ctrl2
// - master clock at least twice timer source
// - test bit makes clock output pin input
// - sixty-four test edges make one second
// - hold bit forces pre-scaler to zero
// - first second after thirty-two edges
// - entry into test mode unaligned
// - recognised toggle sequence ends power-on reset
// - clearing permit bit ends and blocks override
// - master starts only on idle bus
// - data stable while clock high
// - falling data start, rising data stop
// - any byte count, each byte acknowledged
// - acknowledger holds data low clock high
// - master nacks last byte, slave releases
// - first byte after start addresses device
// - device is slave only, clock input
// - pointer uses low four bits only
`timescale 1ns/1ps
module rtcct_device
  import rtcct_pkg::*;
#(
  parameter int unsigned por_cycles = 8192,
  parameter int unsigned override_toggles = 4
) (
  input wire logic hclk,
  input wire logic hresetn,
  rtcct_if.slave bus,
  input wire logic clock_output_pin_i,
  output logic clock_output_pin_o,
  output logic clock_output_pin_oe,
  output logic timer_irq_n,
  output logic [7:0] seconds_o
);
  typedef enum logic [4:0] {
    rtcct_s_idle = 5'b00001,
    rtcct_s_rx = 5'b00010,
    rtcct_s_ack = 5'b00100,
    rtcct_s_tx = 5'b01000,
    rtcct_s_mack = 5'b10000
  } rtcct_slv_type;
  localparam int unsigned div4096 = clk_hz / tick_4096_hz;
  localparam int unsigned div64 = clk_hz / tick_64_hz;
  initial begin
    if (por_cycles < 1 || override_toggles < 1) $error("bad device parameters");
  end
  logic scl_d_r, sda_d_r, in_reset;
  logic [31:0] por_r;
  logic [3:0] tog_r;
  logic override_r;
  logic [7:0] ctrl1_r, ctrl2_r, cd_ctl_r, cd_val_r, sec_r;
  logic [5:0] min_div_r;
  logic [15:0] d4096_r;
  logic [19:0] d64_r;
  logic t4096, t64int, t64, t1, t60, ext_d_r, src_tick;
  rtcct_slv_type st_r;
  logic [7:0] sh_r;
  logic [3:0] bit_r, ptr_r;
  logic rw_r, addr_phase_r, ptr_phase_r, sel_r;
  logic start_c, stop_c, scl_rise, scl_fall;
  logic wr_stb;
  logic [7:0] rd_byte;

  assign scl_rise = bus.scl && !scl_d_r;
  assign scl_fall = !bus.scl && scl_d_r;
  assign start_c = bus.scl && scl_d_r && sda_d_r && !bus.sda;
  assign stop_c = bus.scl && scl_d_r && !sda_d_r && bus.sda;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_d_r <= bus.scl;
      sda_d_r <= bus.sda;
    end
  end

  // power-on reset, cut short by start conditions with clock held high
  assign in_reset = (por_r != 0) && !override_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_r <= 32'(por_cycles);
      tog_r <= 4'h0;
      override_r <= 1'b0;
    end else begin
      if (por_r != 0) por_r <= por_r - 1'b1;
      if (wr_stb && ptr_r == reg_ctrl1 && !sh_r[ctrl1_permit_bit]) begin
        override_r <= 1'b0;
        tog_r <= 4'h0;
      end else if (ctrl1_r[ctrl1_permit_bit] && por_r != 0 && !override_r && start_c) begin
        if (tog_r == 4'(override_toggles - 1)) override_r <= 1'b1;
        else tog_r <= tog_r + 1'b1;
      end
    end
  end

  // timebase
  assign t4096 = (d4096_r == 16'(div4096 - 1));
  assign t64int = (d64_r == 20'(div64 - 1));
  assign t64 = ctrl1_r[ctrl1_ext_bit] ? (clock_output_pin_i && !ext_d_r) : t64int;
  assign t60 = t1 && (min_div_r == minute_last);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      d4096_r <= '0;
      d64_r <= '0;
      ext_d_r <= 1'b0;
      min_div_r <= '0;
      sec_r <= '0;
    end else begin
      d4096_r <= t4096 ? '0 : d4096_r + 1'b1;
      d64_r <= t64int ? '0 : d64_r + 1'b1;
      ext_d_r <= clock_output_pin_i;
      if (t1) begin
        min_div_r <= t60 ? '0 : min_div_r + 1'b1;
        sec_r <= sec_r + 1'b1;
      end
    end
  end
  rtcct_prescale #(.width(6)) u_pre (
    .hclk(hclk),
    .hresetn(hresetn),
    .tick(t64),
    .hold(ctrl1_r[ctrl1_hold_bit]),
    .carry(t1)
  );
  assign clock_output_pin_o = 1'b0;
  assign clock_output_pin_oe = 1'b0;
  assign seconds_o = sec_r;

  always_comb begin
    unique case (cd_ctl_r[1:0])
      src_4096: src_tick = t4096;
      src_64: src_tick = t64;
      src_1: src_tick = t1;
      src_60th: src_tick = t60;
    endcase
  end

  // registers
  assign wr_stb = (st_r == rtcct_s_ack) && scl_fall && !addr_phase_r && !ptr_phase_r && !rw_r && sel_r;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl1_r <= ctrl1_reset;
      ctrl2_r <= '0;
      cd_ctl_r <= cd_control_reset;
      cd_val_r <= '0;
    end else if (!in_reset) begin
      if (cd_ctl_r[cd_run_bit] && src_tick && cd_val_r != 0) begin
        cd_val_r <= cd_val_r - 1'b1;
      end
      if (wr_stb) begin
        unique case (ptr_r)
          reg_ctrl1: ctrl1_r <= sh_r;
          reg_ctrl2: ctrl2_r <= {sh_r[7:3], sh_r[ctrl2_tflag_bit] & ctrl2_r[ctrl2_tflag_bit], sh_r[1:0]};
          reg_countdown_control: cd_ctl_r <= sh_r;
          reg_countdown_value: cd_val_r <= sh_r;
          default: ;
        endcase
      end
      // placed after the write so a same-cycle clear loses to the set
      if (cd_ctl_r[cd_run_bit] && src_tick && cd_val_r == 8'h01) begin
        ctrl2_r[ctrl2_tflag_bit] <= 1'b1;
      end
    end
  end
  assign timer_irq_n = !(ctrl2_r[ctrl2_tflag_bit] && ctrl2_r[ctrl2_tie_bit]);

  always_comb begin
    unique case (ptr_r)
      reg_ctrl1: rd_byte = ctrl1_r;
      reg_ctrl2: rd_byte = ctrl2_r;
      reg_seconds: rd_byte = sec_r;
      reg_countdown_control: rd_byte = cd_ctl_r;
      reg_countdown_value: rd_byte = cd_val_r;
      default: rd_byte = 8'h00;
    endcase
  end

  // serial slave
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= rtcct_s_idle;
      sh_r <= '0;
      bit_r <= '0;
      ptr_r <= '0;
      rw_r <= 1'b0;
      addr_phase_r <= 1'b0;
      ptr_phase_r <= 1'b0;
      sel_r <= 1'b0;
      bus.sda_s_o <= 1'b1;
      bus.sda_s_oe <= 1'b0;
    end else if (in_reset || stop_c) begin
      st_r <= rtcct_s_idle;
      bus.sda_s_oe <= 1'b0;
    end else if (start_c) begin
      st_r <= rtcct_s_rx;
      bit_r <= '0;
      addr_phase_r <= 1'b1;
      sel_r <= 1'b0;
      bus.sda_s_oe <= 1'b0;
    end else begin
      unique case (st_r)
        rtcct_s_idle: ;
        rtcct_s_rx: if (scl_rise) begin
          sh_r <= {sh_r[6:0], bus.sda};
          bit_r <= bit_r + 1'b1;
        end else if (scl_fall && bit_r == 4'h8) begin
          bit_r <= '0;
          if (addr_phase_r && sh_r[7:1] != slave_addr) begin
            st_r <= rtcct_s_idle;
          end else begin
            st_r <= rtcct_s_ack;
            bus.sda_s_o <= 1'b0;
            bus.sda_s_oe <= 1'b1;
          end
        end
        rtcct_s_ack: if (scl_fall) begin
          bus.sda_s_oe <= 1'b0;
          if (addr_phase_r) begin
            addr_phase_r <= 1'b0;
            sel_r <= 1'b1;
            rw_r <= sh_r[0];
            ptr_phase_r <= !sh_r[0];
            if (sh_r[0]) begin
              st_r <= rtcct_s_tx;
              bus.sda_s_o <= rd_byte[7];
              bus.sda_s_oe <= 1'b1;
              sh_r <= {rd_byte[6:0], 1'b0};
              bit_r <= 4'h1;
            end else st_r <= rtcct_s_rx;
          end else if (ptr_phase_r) begin
            ptr_phase_r <= 1'b0;
            ptr_r <= sh_r[3:0];
            st_r <= rtcct_s_rx;
          end else begin
            ptr_r <= ptr_r + 1'b1;
            st_r <= rtcct_s_rx;
          end
        end
        rtcct_s_tx: if (scl_fall) begin
          if (bit_r == 4'h8) begin
            bus.sda_s_oe <= 1'b0;
            st_r <= rtcct_s_mack;
            ptr_r <= ptr_r + 1'b1;
          end else begin
            bus.sda_s_o <= sh_r[7];
            sh_r <= {sh_r[6:0], 1'b0};
            bit_r <= bit_r + 1'b1;
          end
        end
        rtcct_s_mack: if (scl_rise) begin
          if (bus.sda) st_r <= rtcct_s_idle;
          else begin
            st_r <= rtcct_s_ack;
            addr_phase_r <= 1'b1;
            sh_r <= {slave_addr, 1'b1};
          end
        end
        default: st_r <= rtcct_s_idle;
      endcase
    end
  end
endmodule

// File: rtl/rtcct_host.sv
// Purpose: ahb-lite controlled two-wire master doing single register transfers
// Assumes: one slave on the link
// Notes: cmd word starts a transfer; status bit 0 busy, bit 1 nack
// Notes on behaviour: see device file list
`timescale 1ns/1ps
module rtcct_host
  import rtcct_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  rtcct_if.master bus
);
  typedef enum logic [4:0] {
    rtcct_h_idle = 5'b00001,
    rtcct_h_start = 5'b00010,
    rtcct_h_bit = 5'b00100,
    rtcct_h_stop = 5'b01000,
    rtcct_h_done = 5'b10000
  } rtcct_hst_type;
  localparam logic [3:0] ack_bit = 4'h8;
  localparam logic [1:0] restart_after = 2'h1;
  localparam logic [1:0] wr_last = 2'h2;
  localparam logic [1:0] rd_last = 2'h3;
  rtcct_hst_type st_r;
  logic [15:0] div_r, cnt_r;
  logic [7:0] rdata_r;
  logic busy_r, nack_r, wr_pend_r, rd_cmd_r, tick, last_byte;
  logic [7:0] wa_r;
  logic [31:0] seq_r;
  logic [7:0] got_r;
  logic [1:0] q_r, byte_r;
  logic [3:0] bit_r;
  assign hreadyout = 1'b1;
  // open drain: lines are only ever pulled low, the enables do the work
  assign bus.scl_o = 1'b0;
  assign bus.sda_m_o = 1'b0;
  assign tick = (cnt_r == div_r);
  // a write sends three bytes; a read two, a repeated start, then two more
  assign last_byte = rd_cmd_r ? (byte_r == rd_last) : (byte_r == wr_last);
  assign hresp = 1'b0;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wa_r <= '0;
    end else begin
      wr_pend_r <= hsel && hready && htrans == htrans_nonseq && hwrite;
      if (hsel && hready) wa_r <= haddr[7:0];
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= '0;
    else if (hsel && hready && htrans == htrans_nonseq && !hwrite) begin
      unique case (haddr[7:0])
        host_data_off: hrdata <= {24'h0, rdata_r};
        host_stat_off: hrdata <= {30'h0, nack_r, busy_r};
        host_div_off: hrdata <= {16'h0, div_r};
        default: hrdata <= '0;
      endcase
    end
  end
  // one bus transfer: start, address+w, pointer, then data or restart+read
  // every bit takes four quarters: set data, raise clock, sample, lower clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_r <= rtcct_h_idle;
      div_r <= host_div_reset;
      cnt_r <= '0;
      busy_r <= 1'b0;
      nack_r <= 1'b0;
      rd_cmd_r <= 1'b0;
      rdata_r <= '0;
      seq_r <= '0;
      q_r <= '0;
      byte_r <= '0;
      bit_r <= '0;
      got_r <= '0;
      bus.scl_oe <= 1'b0;
      bus.sda_m_oe <= 1'b0;
    end else begin
      if (wr_pend_r && wa_r == host_div_off) div_r <= hwdata[15:0];
      if (st_r != rtcct_h_idle) cnt_r <= tick ? '0 : cnt_r + 1'b1;
      if (st_r != rtcct_h_idle && tick) q_r <= q_r + 1'b1;
      unique case (st_r)
        rtcct_h_idle: if (wr_pend_r && wa_r == host_cmd_off && hwdata[cmd_go_bit] && bus.scl && bus.sda) begin
          st_r <= rtcct_h_start;
          busy_r <= 1'b1;
          nack_r <= 1'b0;
          rd_cmd_r <= hwdata[cmd_read_bit];
          seq_r <= {slave_addr, 1'b0, hwdata[cmd_addr_lsb +: 8],
                    (hwdata[cmd_read_bit] ? {slave_addr, 1'b1} : hwdata[7:0]), 8'hff};
          cnt_r <= '0;
          q_r <= '0;
          byte_r <= '0;
          bit_r <= '0;
        end
        rtcct_h_start: if (tick) begin
          unique case (q_r)
            2'h0: bus.sda_m_oe <= 1'b0;
            2'h1: bus.scl_oe <= 1'b0;
            2'h2: bus.sda_m_oe <= 1'b1;
            2'h3: begin
              bus.scl_oe <= 1'b1;
              st_r <= rtcct_h_bit;
            end
          endcase
        end
        rtcct_h_bit: if (tick) begin
          unique case (q_r)
            2'h0: bus.sda_m_oe <= (bit_r != ack_bit) && !seq_r[31];
            2'h1: bus.scl_oe <= 1'b0;
            2'h2: begin
              if (bit_r != ack_bit) got_r <= {got_r[6:0], bus.sda};
              else if (bus.sda && !(rd_cmd_r && last_byte)) nack_r <= 1'b1;
            end
            2'h3: begin
              bus.scl_oe <= 1'b1;
              if (bit_r != ack_bit) begin
                bit_r <= bit_r + 1'b1;
                seq_r <= {seq_r[30:0], 1'b1};
              end else begin
                bit_r <= '0;
                byte_r <= byte_r + 1'b1;
                if (nack_r || last_byte) st_r <= rtcct_h_stop;
                else if (rd_cmd_r && byte_r == restart_after) st_r <= rtcct_h_start;
              end
            end
          endcase
        end
        rtcct_h_stop: if (tick) begin
          unique case (q_r)
            2'h0: bus.sda_m_oe <= 1'b1;
            2'h1: bus.scl_oe <= 1'b0;
            2'h2: bus.sda_m_oe <= 1'b0;
            2'h3: st_r <= rtcct_h_done;
          endcase
        end
        rtcct_h_done: begin
          st_r <= rtcct_h_idle;
          busy_r <= 1'b0;
          rdata_r <= got_r;
        end
        default: st_r <= rtcct_h_idle;
      endcase
    end
  end
endmodule

// File: rtl/rtcct_prescale.sv
// Purpose: divide a tick stream by a power of two, with hold and half-way first carry
// Assumes: tick is a one-cycle pulse
// Notes: hold forces the count to zero
`timescale 1ns/1ps
module rtcct_prescale #(
  parameter int unsigned width = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic tick,
  input wire logic hold,
  output logic carry
);
  logic [width-1:0] cnt_r;
  logic first_r;
  initial begin
    if (width < 2) $error("prescale width too small");
  end
  // after a hold the first carry comes at the half way point
  always_comb begin
    if (first_r) begin
      carry = tick && (cnt_r == {1'b0, {(width-1){1'b1}}});
    end else begin
      carry = tick && (cnt_r == {width{1'b1}});
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_r <= '0;
      first_r <= 1'b0;
    end else if (hold) begin
      cnt_r <= '0;
      first_r <= 1'b1;
    end else if (tick) begin
      if (carry && first_r) begin
        cnt_r <= '0;
        first_r <= 1'b0;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule

// File: shared/rtcct_if.sv
// Purpose: two-wire serial link between master and slave
// Assumes: open drain, pulled up when nobody pulls low
// Notes: wire levels are resolved here
`timescale 1ns/1ps
interface rtcct_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;
  assign scl = !(scl_oe && !scl_o);
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport master (output scl_o, output scl_oe, output sda_m_o, output sda_m_oe, input scl, input sda);
  modport slave (output sda_s_o, output sda_s_oe, input scl, input sda);
endinterface

// File: shared/rtcct_pkg.sv
// Purpose: shared constants for the countdown timer device and its serial bus master
// Assumes: one 40 MHz clock hclk, device registers one byte wide
// Notes: device register map and host command registers
package rtcct_pkg;
  localparam int unsigned clk_hz = 40000000;
  // device register indices on the serial link
  localparam logic [3:0] reg_ctrl1 = 4'h0;
  localparam logic [3:0] reg_ctrl2 = 4'h1;
  localparam logic [3:0] reg_seconds = 4'h2;
  localparam logic [3:0] reg_countdown_control = 4'he;
  localparam logic [3:0] reg_countdown_value = 4'hf;
  // ctrl1 fields
  localparam int unsigned ctrl1_ext_bit = 7;
  localparam int unsigned ctrl1_hold_bit = 5;
  localparam int unsigned ctrl1_permit_bit = 3;
  localparam logic [7:0] ctrl1_reset = 8'h08;
  // ctrl2 fields
  localparam int unsigned ctrl2_tflag_bit = 2;
  localparam int unsigned ctrl2_tie_bit = 0;
  // countdown control fields
  localparam int unsigned cd_run_bit = 7;
  localparam logic [7:0] cd_control_reset = 8'h03;
  localparam logic [1:0] src_4096 = 2'h0;
  localparam logic [1:0] src_64 = 2'h1;
  localparam logic [1:0] src_1 = 2'h2;
  localparam logic [1:0] src_60th = 2'h3;
  // timebase frequencies and counts
  localparam int unsigned tick_4096_hz = 4096;
  localparam int unsigned tick_64_hz = 64;
  localparam int unsigned prescale_steps = 64;
  localparam logic [5:0] prescale_half = 6'h20;
  localparam logic [5:0] prescale_last = 6'h3f;
  localparam logic [5:0] minute_last = 6'h3b;
  // serial slave address, arbitrary value
  localparam logic [6:0] slave_addr = 7'h51;
  // host ahb registers
  localparam logic [7:0] host_cmd_off = 8'h00;
  localparam logic [7:0] host_data_off = 8'h04;
  localparam logic [7:0] host_stat_off = 8'h08;
  localparam logic [7:0] host_div_off = 8'h0c;
  localparam int unsigned cmd_go_bit = 31;
  localparam int unsigned cmd_read_bit = 30;
  localparam int unsigned cmd_addr_lsb = 8;
  localparam logic [15:0] host_div_reset = 16'h0032;
  localparam logic [1:0] htrans_nonseq = 2'h2;
endpackage

// File: sim/rtc_countdown_timer_test_port_bench.sv
// Purpose: host and device joined over the link, driven from the AHB side
// Assumes: por_cycles shortened to 16, divider set to 16
// Notes: register values judged by reading them back over the link; seconds and pin drive judged at the device ports
`timescale 1ns/1ps
module rtc_countdown_timer_test_port_bench
  import rtcct_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, ck_in, pin_o, pin_oe, irq_n;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] sec, q;
  int n_mismatch = 0;
  int check_count = 0;
  int cyc = 0;
  rtcct_if lnk();
  assign hready = hreadyout;
  rtcct_host u_rtcct_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus(lnk.master));
  rtcct_device #(.por_cycles(16)) u_rtcct_device (.hclk(hclk), .hresetn(hresetn), .bus(lnk.slave),
    .clock_output_pin_i(ck_in), .clock_output_pin_o(pin_o), .clock_output_pin_oe(pin_oe),
    .timer_irq_n(irq_n), .seconds_o(sec));
  rtcct_monitor u_rtcct_monitor (.hclk(hclk), .hresetn(hresetn), .sda_s_o(lnk.sda_s_o),
    .sda_s_oe(lnk.sda_s_oe), .scl(lnk.scl), .sda(lnk.sda));
  initial begin
    hclk = 1'b0;
    forever #12.5 hclk = ~hclk;
  end
  task close_out;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= htrans_nonseq;
    haddr <= {24'h0, a};
    hwrite <= w;
    hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // one register transfer over the link; nack must stay clear
  task dev(input logic r, input logic [7:0] a, input logic [7:0] d);
    int i;
    ahb(1'b1, host_data_off, {24'h0, d});
    ahb(1'b1, host_cmd_off, (32'h1 << cmd_go_bit) | ({31'h0, r} << cmd_read_bit)
      | ({24'h0, a} << cmd_addr_lsb) | {24'h0, d});
    i = 0;
    do begin
      ahb(1'b0, host_stat_off, 32'h0);
      i++;
    end while (rd[0] !== 1'b0 && i < 5000);
    chk("link busy", 32'h0, {31'h0, rd[0]});
    chk("link nack", 32'h0, {31'h0, rd[1]});
    ahb(1'b0, host_data_off, 32'h0);
    q = rd[7:0];
  endtask
  task pulses(input int n);
    repeat (n) begin
      ck_in <= 1'b1;
      repeat (20) @(posedge hclk);
      ck_in <= 1'b0;
      repeat (20) @(posedge hclk);
    end
  endtask
  task t_regs;
    ahb(1'b0, host_div_off, 32'h0);
    chk("divider reset", {16'h0, host_div_reset}, rd);
    ahb(1'b1, host_div_off, 32'h10);
    dev(1'b0, {4'h3, reg_countdown_value}, 8'h5a);
    dev(1'b1, {4'h0, reg_countdown_value}, 8'h00);
    chk("value by high pointer", 32'h5a, {24'h0, q});
    dev(1'b0, {4'h0, reg_countdown_control}, {6'h0, src_1});
    dev(1'b1, {4'h0, reg_countdown_control}, 8'h00);
    chk("control readback", {30'h0, src_1}, {24'h0, q});
  endtask
  task t_halt;
    dev(1'b0, {4'h0, reg_countdown_value}, 8'h05);
    dev(1'b0, {4'h0, reg_countdown_control}, {6'h0, src_4096});
    repeat (11000) @(posedge hclk);
    dev(1'b1, {4'h0, reg_countdown_value}, 8'h00);
    chk("halted value", 32'h05, {24'h0, q});
  endtask
  task t_run;
    dev(1'b0, {4'h0, reg_ctrl2}, 8'h01);
    dev(1'b0, {4'h0, reg_countdown_value}, 8'h02);
    dev(1'b0, {4'h0, reg_countdown_control}, 8'h80 | {6'h0, src_4096});
    dev(1'b1, {4'h0, reg_ctrl2}, 8'h00);
    chk("flag early", 32'h01, {24'h0, q & 8'h05});
    repeat (22000) @(posedge hclk);
    dev(1'b1, {4'h0, reg_ctrl2}, 8'h00);
    chk("flag at zero", 32'h05, {24'h0, q & 8'h05});
    chk("irq", 32'h0, {31'h0, irq_n});
  endtask
  task t_ext;
    dev(1'b0, {4'h0, reg_seconds}, 8'h00);
    dev(1'b0, {4'h0, reg_ctrl1}, 8'ha8);
    chk("pin enable", 32'h0, {31'h0, pin_oe});
    chk("pin drive", 32'h0, {31'h0, pin_o});
    pulses(40);
    chk("held seconds", 32'h0, {24'h0, sec});
    dev(1'b0, {4'h0, reg_ctrl1}, 8'h88);
    pulses(31);
    chk("seconds at 31", 32'h0, {24'h0, sec});
    pulses(1);
    chk("seconds at 32", 32'h1, {24'h0, sec});
    pulses(63);
    chk("seconds at 95", 32'h1, {24'h0, sec});
    pulses(1);
    chk("seconds at 96", 32'h2, {24'h0, sec});
  endtask
  always @(posedge hclk) begin
    cyc++;
    if (cyc == 90000) begin
      n_mismatch++;
      close_out;
    end
  end
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    htrans = 2'h0;
    hsize = 3'h2;
    haddr = 32'h0;
    hwdata = 32'h0;
    ck_in = 1'b0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (40) @(posedge hclk);
    t_regs;
    t_halt;
    t_run;
    t_ext;
    close_out;
  end
endmodule

// File: sim/rtcct_monitor.sv
// Purpose: protocol checks on the two-wire link between host and device
// Assumes: scl and sda are the resolved wire levels from the interface
// Notes: bit position is tracked from scl rises since the last start
`timescale 1ns/1ps
module rtcct_monitor
  import rtcct_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda
);
  logic s_low, rise, start, stop, scl_q_r, sda_q_r, first_r, rd_r;
  logic [3:0] bc_r;
  logic [7:0] sh_r;
  logic [4:0] por_r;
  assign s_low = sda_s_oe && !sda_s_o;
  assign rise = scl && !scl_q_r;
  assign start = scl && scl_q_r && sda_q_r && !sda;
  assign stop = scl && scl_q_r && !sda_q_r && sda;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q_r <= 1'b1;
      sda_q_r <= 1'b1;
    end else begin
      scl_q_r <= scl;
      sda_q_r <= sda;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bc_r <= 4'h0;
      first_r <= 1'b0;
      sh_r <= 8'h00;
      rd_r <= 1'b0;
    end else if (start) begin
      bc_r <= 4'h0;
      first_r <= 1'b1;
    end else if (rise) begin
      sh_r <= {sh_r[6:0], sda};
      if (bc_r == 4'h8) begin
        bc_r <= 4'h0;
        first_r <= 1'b0;
      end else begin
        bc_r <= bc_r + 4'h1;
      end
      if (first_r && bc_r == 4'h8) begin
        rd_r <= sh_r[0];
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      por_r <= 5'h00;
    end else if (por_r != 5'h1f) begin
      por_r <= por_r + 5'h01;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // ninth clock of a byte
  sequence ack_clock;
    rise && bc_r == 4'h8;
  endsequence
  sequence master_nack;
    ack_clock ##0 (rd_r && !first_r && sda);
  endsequence
  a_slave_stable: assert property (scl && scl_q_r |-> $stable(s_low))
    else $error("device changed data while clock high");
  a_start_slave: assert property (start |-> !s_low)
    else $error("device pulled data at start");
  a_stop_release: assert property (stop |=> !s_low [*2])
    else $error("device pulled data after stop");
  a_addr_ack: assert property (ack_clock ##0 (first_r && sh_r[7:1] == slave_addr) |-> s_low)
    else $error("device did not acknowledge its address");
  a_ack_hold: assert property (rise && s_low |-> s_low [*3])
    else $error("acknowledge not held through clock high");
  a_nack_release: assert property (master_nack |=> !s_low [*2])
    else $error("device kept data after master nack");
  a_start_idle: assert property (start |-> $past(scl, 2))
    else $error("start without idle clock");
  a_por_quiet: assert property (por_r < 5'h10 |-> !s_low)
    else $error("device answered during power-on reset");
endmodule
